// ==== pdd_pkg.sv ====
// Shared constants, descriptor layout and state codes of the descriptor DMA.
package pdd_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_TX_HEAD   = 8'h04;
  localparam logic [7:0] REG_RX_HEAD   = 8'h08;
  localparam logic [7:0] REG_RX_OFFSET = 8'h0C;
  localparam logic [7:0] REG_STATUS    = 8'h10;
  localparam logic [7:0] REG_TX_DONE   = 8'h14;

  // Control register bits.
  localparam int CTRL_ACCEPT_ERR = 0;
  localparam int CTRL_TX_TDOWN   = 1;
  localparam int CTRL_RX_TDOWN   = 2;

  // Status register bits and error code field.
  localparam int STAT_HOST_ERR   = 0;
  localparam int STAT_BUSY       = 1;
  localparam int STAT_TX_TD_DONE = 2;
  localparam int STAT_RX_TD_DONE = 3;
  localparam int STAT_CODE_LSB   = 8;

  // Descriptor word byte offsets inside one four-word descriptor.
  localparam logic [31:0] DW_LEN_OFS   = 32'h0000_0008;
  localparam logic [31:0] DW_FLAG_OFS  = 32'h0000_000C;
  localparam logic [31:0] DW_STRIDE    = 32'h0000_0004;

  // Word 2: buffer offset in the upper half, buffer length in the lower.
  localparam int OFS_LSB  = 16;
  localparam int OFS_W    = 12;
  localparam int LEN_W    = 16;
  localparam int RXLEN_W  = 12;

  // Word 3: flags in the upper half, packet length in the lower half.
  localparam int F_FIRST     = 31;
  localparam int F_LAST      = 30;
  localparam int F_OWN       = 29;
  localparam int F_QEMPTY    = 28;
  localparam int F_TDOWN     = 27;
  localparam int F_PASS_CRC  = 26;
  localparam int F_JABBER    = 25;
  localparam int F_OVERSIZE  = 24;
  localparam int F_DIRECTED  = 20;
  localparam int F_PORT      = 16;
  localparam int PORT_W      = 2;

  // Reset value of every 32-bit register.
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Host error codes.
  localparam logic [3:0] ERR_NONE   = 4'h0;
  localparam logic [3:0] ERR_OWN    = 4'h1;
  localparam logic [3:0] ERR_PTR    = 4'h2;
  localparam logic [3:0] ERR_LEN    = 4'h3;
  localparam logic [3:0] ERR_LINK   = 4'h4;
  localparam logic [3:0] ERR_PKTLEN = 4'h5;
  localparam logic [3:0] ERR_RXCAP  = 4'h6;

  // Engine states, Gray coded along fetch, segment and write-back.
  typedef enum logic [2:0] {
    PDD_IDLE  = 3'b000,
    PDD_FETCH = 3'b001,
    PDD_SEG   = 3'b011,
    PDD_WLEN  = 3'b010,
    PDD_WLAST = 3'b110,
    PDD_WSOP  = 3'b111,
    PDD_TDOWN = 3'b101
  } pdd_state_t;

endpackage

// ==== pdd_mem_if.sv ====
// Command path between the engine and its descriptor word mover.
`timescale 1ns/1ps
interface pdd_mem_if;
  logic        start;
  logic        wr;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic        done;
  logic [31:0] word [4];

  modport eng (output start, wr, addr, wdata, input done, word);
  modport mov (input start, wr, addr, wdata, output done, word);
endinterface

// ==== pdd_mover.sv ====
// Descriptor word mover: reads four words or writes one word of a descriptor.
`timescale 1ns/1ps
module pdd_mover
  import pdd_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  arst_n,
  pdd_mem_if.mov     cmd,
  output logic       mem_req,
  output logic       mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input  wire logic [31:0] mem_rdata,
  input  wire logic  mem_ack
);

  logic        busy;
  logic        is_wr;
  logic [1:0]  idx;
  logic [31:0] base;
  logic        done_q;

  assign cmd.done = done_q;

  // Request sequencer; one word at a time keeps the memory side simple.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy      <= 1'b0;
      is_wr     <= 1'b0;
      idx       <= 2'h0;
      base      <= RST_WORD;
      done_q    <= 1'b0;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= RST_WORD;
      mem_wdata <= RST_WORD;
    end else begin
      done_q <= 1'b0;
      if (!busy && cmd.start) begin
        busy      <= 1'b1;
        is_wr     <= cmd.wr;
        idx       <= 2'h0;
        base      <= cmd.addr;
        mem_req   <= 1'b1;
        mem_we    <= cmd.wr;
        mem_addr  <= cmd.addr;
        mem_wdata <= cmd.wdata;
      end else if (busy && mem_ack) begin
        if (is_wr || idx == 2'h3) begin
          busy    <= 1'b0;
          mem_req <= 1'b0;
          mem_we  <= 1'b0;
          done_q  <= 1'b1;
        end else begin
          idx      <= idx + 2'h1;
          mem_addr <= base + {28'h0000000, idx + 2'h1, 2'h0};
        end
      end
    end
  end

  // Four captured descriptor words, one register per word.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_word
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          cmd.word[g] <= RST_WORD;
        end else if (busy && mem_ack && !is_wr && idx == 2'(g)) begin
          cmd.word[g] <= mem_rdata;
        end
      end
    end
  endgenerate

endmodule

// ==== pdd_engine.sv ====
// Packet descriptor DMA engine: walks transmit and receive descriptor lists.
`timescale 1ns/1ps
// What this block does
// - Descriptors are four aligned 32-bit words, fetched and updated in place.
// - Word zero links the next descriptor; zero marks the queue's end.
// - Transmit first buffer skips its offset count of leading bytes.
// - First and last flags bound a packet spanning chained descriptors.
// - Software sets ownership on first descriptor; engine clears it when done.
// - Transmit last descriptor with zero link gets the queue-empty flag.
// - Finished teardown sets the teardown-done flag in a first descriptor.
// - Host-CRC flag clear: device appends its own generated CRC.
// - Host-CRC flag set: device sends the buffer's last four CRC bytes.
// - Directed flag forwards the packet to exactly one indexed port.
// - Directed port index 0 means port 0, index 1 means port 1.
// - Packet length below buffer sum truncates the packet to that length.
// - Packet length above buffer sum is a host error.
// - Receive first descriptor gets the configured 12-bit receive offset.
// - Receive first length is rewritten when short or offset nonzero.
// - Receive last length is rewritten when buffer is not filled.
// - Engine sets first and last flags on stored receive packets.
// - Receive last descriptor with zero link gets the queue-empty flag.
// - Packet stored with CRC sets CRC flag; length counts CRC bytes.
// - Accepted jabber frame sets jabber flag in first receive descriptor.
// - Accepted oversize frame sets oversize flag in first receive descriptor.
// - Writing a nonzero transmit head pointer starts transmit fetching.
// - Missing ownership, zero buffer address or zero length is host error.
module pdd_engine
  import pdd_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_ack,
  output logic             tx_seg_valid,
  input  wire logic        tx_seg_ready,
  output logic [31:0]      tx_seg_addr,
  output logic [15:0]      tx_seg_len,
  output logic             tx_seg_first,
  output logic             tx_seg_last,
  output logic             tx_gen_crc,
  output logic             tx_directed,
  output logic [1:0]       tx_dest_port,
  input  wire logic        rx_pkt_valid,
  input  wire logic [11:0] rx_pkt_len,
  input  wire logic        rx_crc_incl,
  input  wire logic        rx_jabber,
  input  wire logic        rx_oversize,
  output logic             rx_pkt_done,
  output logic [31:0]      rx_buf_addr,
  output logic             host_error,
  output logic             accept_error_frames
);

  pdd_mem_if mif ();

  pdd_mover i_pdd_mover (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .cmd       (mif),
    .mem_req   (mem_req),
    .mem_we    (mem_we),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_rdata (mem_rdata),
    .mem_ack   (mem_ack)
  );

  pdd_state_t         state;
  logic [31:0]        tx_head;
  logic [31:0]        rx_head;
  logic [OFS_W-1:0]   rx_offset;
  logic [31:0]        tx_done_ptr;
  logic               tx_tdown_req;
  logic               rx_tdown_req;
  logic               tx_td_done;
  logic               rx_td_done;
  logic [3:0]         err_code;
  logic               is_rx;
  logic               first;
  logic [31:0]        cur;
  logic [31:0]        sop_addr;
  logic [31:0]        sop_flags;
  logic [LEN_W-1:0]   rem;
  logic [LEN_W-1:0]   used;
  logic               last_desc;
  logic               mstart;
  logic               mwr;
  logic [31:0]        maddr;
  logic [31:0]        mwdata;
  logic               err_set;
  logic               tx_td_set;
  logic               rx_td_set;

  assign mif.start = mstart;
  assign mif.wr    = mwr;
  assign mif.addr  = maddr;
  assign mif.wdata = mwdata;

  // Fields of the descriptor just fetched.
  wire [31:0]      d_next   = mif.word[0];
  wire [31:0]      d_buf    = mif.word[1];
  wire [LEN_W-1:0] d_len    = mif.word[2][LEN_W-1:0];
  wire [LEN_W-1:0] d_ofs    = {4'h0, mif.word[2][OFS_LSB +: OFS_W]};
  wire [31:0]      d_flags  = mif.word[3];
  wire [LEN_W-1:0] d_pkt    = mif.word[3][LEN_W-1:0];
  wire             d_done   = mif.done;

  // Bus decode; a request is taken in the cycle waitrequest is low.
  wire bus_req   = (avs_read || avs_write) && avs_waitrequest;
  wire bus_take  = (avs_read || avs_write) && !avs_waitrequest;
  wire wr_take   = avs_write && !avs_waitrequest;
  wire wr_ctrl   = wr_take && avs_address == REG_CTRL;
  wire wr_txhead = wr_take && avs_address == REG_TX_HEAD;
  wire wr_rxhead = wr_take && avs_address == REG_RX_HEAD;
  wire wr_rxofs  = wr_take && avs_address == REG_RX_OFFSET;
  wire wr_stat   = wr_take && avs_address == REG_STATUS;
  wire busy      = state != PDD_IDLE;

  // Transmit length bookkeeping: remaining count, this segment, descriptor faults.
  wire [LEN_W-1:0] tx_rem  = first ? d_pkt : rem;
  wire [LEN_W-1:0] tx_take = (d_len < tx_rem) ? d_len : tx_rem;
  wire             tx_bad_first = first && (!d_flags[F_FIRST]
                                  || !d_flags[F_OWN] || d_pkt == '0);
  wire             tx_bad_ptr = d_buf == '0 || d_len == '0;
  wire             tx_bad_link = !d_flags[F_LAST] && d_next == '0;

  // Receive capacity: the first buffer loses the configured offset.
  wire [LEN_W-1:0] rx_ofs16 = {4'h0, rx_offset};
  wire [LEN_W-1:0] rx_cap   = first ? (d_len - rx_ofs16) : d_len;
  wire [LEN_W-1:0] rx_rem   = first ? {4'h0, rx_pkt_len} : rem;
  wire [LEN_W-1:0] rx_take  = (rx_cap < rx_rem) ? rx_cap : rx_rem;
  wire             rx_bad_own = first && !d_flags[F_OWN];
  wire             rx_bad_len = first ? (d_len <= rx_ofs16)
                                      : (d_len == '0);

  // Flag words written back at the end of a packet.
  wire [31:0] eop_bits  = (32'h1 << F_LAST)
                        | ((d_next == '0) ? (32'h1 << F_QEMPTY) : 32'h0);
  wire [31:0] tx_qempty = (d_next == '0) ? (32'h1 << F_QEMPTY) : 32'h0;
  wire [31:0] rx_sop_w  = (32'h1 << F_FIRST)
                        | (32'(rx_crc_incl) << F_PASS_CRC)
                        | (32'(accept_error_frames && rx_jabber) << F_JABBER)
                        | (32'(accept_error_frames && rx_oversize)
                           << F_OVERSIZE)
                        | {20'h00000, rx_pkt_len};
  wire [31:0] own_clear = ~(32'h1 << F_OWN);
  wire        one_desc  = cur == sop_addr;

  // Read multiplexer; unmapped offsets read as zero.
  wire [31:0] status_w = {20'h00000, err_code, 4'h0, rx_td_done,
                          tx_td_done, busy, host_error};
  wire [31:0] rd_mux =
      (avs_address == REG_CTRL)      ? {29'h0, rx_tdown_req, tx_tdown_req,
                                        accept_error_frames} :
      (avs_address == REG_TX_HEAD)   ? tx_head :
      (avs_address == REG_RX_HEAD)   ? rx_head :
      (avs_address == REG_RX_OFFSET) ? {20'h00000, rx_offset} :
      (avs_address == REG_STATUS)    ? status_w :
      (avs_address == REG_TX_DONE)   ? tx_done_ptr : 32'h0000_0000;

  // Avalon answer: waitrequest drops one cycle after the request rises.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= RST_WORD;
    end else begin
      avs_waitrequest <= !bus_req;
      if (bus_req && avs_read) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // Software configuration; the teardown request clears when it completes.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      accept_error_frames <= 1'b0;
      rx_offset           <= '0;
    end else begin
      if (wr_ctrl) begin
        accept_error_frames <= avs_writedata[CTRL_ACCEPT_ERR];
      end
      if (wr_rxofs) begin
        rx_offset <= avs_writedata[OFS_W-1:0];
      end
    end
  end

  // Status flags; a hardware set wins over a software write-one clear.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_error <= 1'b0;
      tx_td_done <= 1'b0;
      rx_td_done <= 1'b0;
    end else begin
      host_error <= (err_set) ||
                    (host_error && !(wr_stat && avs_writedata[STAT_HOST_ERR]));
      tx_td_done <= tx_td_set || (tx_td_done
                    && !(wr_stat && avs_writedata[STAT_TX_TD_DONE]));
      rx_td_done <= rx_td_set || (rx_td_done
                    && !(wr_stat && avs_writedata[STAT_RX_TD_DONE]));
    end
  end

  // Descriptor walker shared by both directions over one memory port.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= PDD_IDLE;       tx_head <= RST_WORD;   rx_head <= RST_WORD;
      tx_done_ptr <= RST_WORD; tx_tdown_req <= 1'b0;  rx_tdown_req <= 1'b0;
      err_code <= ERR_NONE;    err_set <= 1'b0;       tx_td_set <= 1'b0;
      rx_td_set <= 1'b0;       is_rx <= 1'b0;         first <= 1'b0;
      cur <= RST_WORD;         sop_addr <= RST_WORD;  sop_flags <= RST_WORD;
      rem <= '0;               used <= '0;            last_desc <= 1'b0;
      mstart <= 1'b0;          mwr <= 1'b0;           maddr <= RST_WORD;
      mwdata <= RST_WORD;      tx_seg_valid <= 1'b0;  tx_seg_addr <= RST_WORD;
      tx_seg_len <= '0;        tx_seg_first <= 1'b0;  tx_seg_last <= 1'b0;
      tx_gen_crc <= 1'b0;      tx_directed <= 1'b0;   tx_dest_port <= '0;
      rx_pkt_done <= 1'b0;     rx_buf_addr <= RST_WORD;
    end else begin
      mstart      <= 1'b0;
      err_set     <= 1'b0;
      tx_td_set   <= 1'b0;
      rx_td_set   <= 1'b0;
      rx_pkt_done <= 1'b0;
      if (wr_ctrl) begin
        tx_tdown_req <= tx_tdown_req || avs_writedata[CTRL_TX_TDOWN];
        rx_tdown_req <= rx_tdown_req || avs_writedata[CTRL_RX_TDOWN];
      end
      if (wr_txhead) tx_head <= avs_writedata;
      if (wr_rxhead) rx_head <= avs_writedata;
      unique case (state)
        PDD_IDLE: begin
          first <= 1'b1;
          if (tx_tdown_req || rx_tdown_req) begin
            is_rx <= !tx_tdown_req;
            cur   <= tx_tdown_req ? tx_head : rx_head;
            if ((tx_tdown_req ? tx_head : rx_head) != '0) begin
              mstart <= 1'b1;
              mwr    <= 1'b1;
              maddr  <= (tx_tdown_req ? tx_head : rx_head) + DW_FLAG_OFS;
              mwdata <= (32'h1 << F_FIRST) | (32'h1 << F_TDOWN);
              state  <= PDD_TDOWN;
            end else begin
              state <= PDD_TDOWN;
            end
          end else if (tx_head != '0 && !wr_txhead) begin
            is_rx <= 1'b0; cur <= tx_head; sop_addr <= tx_head;
            mstart <= 1'b1; mwr <= 1'b0; maddr <= tx_head;
            state <= PDD_FETCH;
          end else if (rx_pkt_valid && rx_head != '0 && !wr_rxhead) begin
            is_rx <= 1'b1; cur <= rx_head; sop_addr <= rx_head;
            mstart <= 1'b1; mwr <= 1'b0; maddr <= rx_head;
            state <= PDD_FETCH;
          end
        end
        PDD_TDOWN: begin
          if (d_done || maddr != cur + DW_FLAG_OFS || cur == '0) begin
            if (is_rx) begin
              rx_tdown_req <= 1'b0; rx_td_set <= 1'b1; rx_head <= RST_WORD;
            end else begin
              tx_tdown_req <= 1'b0; tx_td_set <= 1'b1; tx_head <= RST_WORD;
            end
            state <= PDD_IDLE;
          end
        end
        PDD_FETCH: begin
          if (d_done && !is_rx) begin
            if (first) sop_flags <= d_flags;
            if (tx_bad_first || tx_bad_ptr || tx_bad_link) begin
              err_code <= tx_bad_first ? ERR_OWN
                        : (tx_bad_ptr ? ERR_PTR : ERR_LINK);
              err_set <= 1'b1; tx_head <= RST_WORD; state <= PDD_IDLE;
            end else begin
              tx_seg_valid <= tx_take != '0;
              tx_seg_addr  <= d_buf + (first ? {16'h0, d_ofs} : 32'h0);
              tx_seg_len   <= tx_take;
              tx_seg_first <= first;
              tx_seg_last  <= d_flags[F_LAST];
              tx_gen_crc   <= !(first ? d_flags[F_PASS_CRC]
                                      : sop_flags[F_PASS_CRC]);
              tx_directed  <= first ? d_flags[F_DIRECTED]
                                    : sop_flags[F_DIRECTED];
              tx_dest_port <= first ? d_flags[F_PORT +: PORT_W]
                                    : sop_flags[F_PORT +: PORT_W];
              rem   <= tx_rem - tx_take;
              state <= PDD_SEG;
            end
          end else if (d_done) begin
            if (rx_bad_own || d_buf == '0 || rx_bad_len) begin
              err_code <= rx_bad_own ? ERR_OWN
                        : (d_buf == '0 ? ERR_PTR : ERR_RXCAP);
              err_set <= 1'b1; rx_head <= RST_WORD; rx_pkt_done <= 1'b1;
              state <= PDD_IDLE;
            end else begin
              used        <= rx_take;
              rem         <= rx_rem - rx_take;
              last_desc   <= rx_take == rx_rem;
              rx_buf_addr <= d_buf + (first ? {20'h0, rx_offset} : 32'h0);
              mstart <= 1'b1; mwr <= 1'b1; maddr <= cur + DW_LEN_OFS;
              mwdata <= {4'h0, (first ? rx_offset : 12'h000),
                         rx_take};
              state  <= PDD_WLEN;
            end
          end
        end
        PDD_SEG: begin
          if (tx_seg_ready || !tx_seg_valid) begin
            tx_seg_valid <= 1'b0;
            first <= 1'b0;
            if (!d_flags[F_LAST]) begin
              cur <= d_next; mstart <= 1'b1; mwr <= 1'b0; maddr <= d_next;
              state <= PDD_FETCH;
            end else if (rem != '0) begin
              err_code <= ERR_PKTLEN; err_set <= 1'b1;
              tx_head <= RST_WORD; state <= PDD_IDLE;
            end else if (!one_desc && d_next == '0) begin
              mstart <= 1'b1; mwr <= 1'b1; maddr <= cur + DW_FLAG_OFS;
              mwdata <= d_flags | tx_qempty;
              state  <= PDD_WLAST;
            end else begin
              mstart <= 1'b1; mwr <= 1'b1; maddr <= sop_addr + DW_FLAG_OFS;
              mwdata <= (sop_flags | (one_desc ? tx_qempty : 32'h0))
                        & own_clear;
              state  <= PDD_WSOP;
            end
          end
        end
        PDD_WLEN: begin
          if (d_done) begin
            first <= 1'b0;
            if (!last_desc && d_next == '0) begin
              err_code <= ERR_LINK; err_set <= 1'b1;
              rx_head <= RST_WORD; rx_pkt_done <= 1'b1; state <= PDD_IDLE;
            end else if (!last_desc) begin
              cur <= d_next; mstart <= 1'b1; mwr <= 1'b0; maddr <= d_next;
              state <= PDD_FETCH;
            end else if (!one_desc) begin
              mstart <= 1'b1; mwr <= 1'b1; maddr <= cur + DW_FLAG_OFS;
              mwdata <= eop_bits;
              state  <= PDD_WLAST;
            end else begin
              mstart <= 1'b1; mwr <= 1'b1; maddr <= sop_addr + DW_FLAG_OFS;
              mwdata <= rx_sop_w | eop_bits;
              state  <= PDD_WSOP;
            end
          end
        end
        PDD_WLAST: begin
          if (d_done) begin
            mstart <= 1'b1; mwr <= 1'b1; maddr <= sop_addr + DW_FLAG_OFS;
            mwdata <= is_rx ? rx_sop_w : (sop_flags & own_clear);
            state  <= PDD_WSOP;
          end
        end
        PDD_WSOP: begin
          if (d_done) begin
            if (is_rx) begin
              rx_head <= d_next; rx_pkt_done <= 1'b1;
            end else begin
              tx_head <= d_next; tx_done_ptr <= cur;
            end
            state <= PDD_IDLE;
          end
        end
      endcase
    end
  end

endmodule

// ==== pdd_engine_monitor.sv ====
// Port checker for the descriptor DMA engine.
`timescale 1ns/1ps
module pdd_engine_monitor
  import pdd_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_ack,
  input wire logic        tx_seg_valid,
  input wire logic        tx_seg_ready,
  input wire logic [15:0] tx_seg_len,
  input wire logic        rx_pkt_done,
  input wire logic        host_error,
  input wire logic        accept_error_frames
);
  // One clock domain, so clock and reset are given once.
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_one_wait: assert property ((avs_read || avs_write)
    && avs_waitrequest |=> !avs_waitrequest) else $error("bus answer late");
  a_req_hold: assert property (mem_req && !mem_ack
    |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("req moved");
  a_word_align: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
    else $error("unaligned word");
  a_seg_hold: assert property (tx_seg_valid && !tx_seg_ready
    |=> tx_seg_valid && $stable(tx_seg_len)) else $error("segment dropped");
  a_seg_len: assert property (tx_seg_valid |-> tx_seg_len != 16'h0)
    else $error("empty segment");
  a_done_pulse: assert property (rx_pkt_done |=> !rx_pkt_done)
    else $error("done too long");
  a_err_sticky: assert property (host_error && !avs_write
    |=> host_error) else $error("error lost");
  a_accept_ctrl: assert property (avs_write && !avs_waitrequest
    && avs_address == REG_CTRL
    |=> accept_error_frames == $past(avs_writedata[0]))
    else $error("accept bit wrong");
  // The main traffic kinds are seen at least once.
  c_seg: cover property (tx_seg_valid && tx_seg_ready);
  c_rx: cover property (rx_pkt_done);
  c_err: cover property ($rose(host_error));
endmodule

// ==== pdd_mem_model.sv ====
// Descriptor memory standing in for host RAM, with a settable answer delay.
`timescale 1ns/1ps
module pdd_mem_model (
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic [1:0]  slow,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic [31:0]     mem_rdata,
  output logic            mem_ack
);
  logic [31:0] mem [256];
  logic [1:0]  cnt;
  // Between answers the read bus toggles, so stale data never looks fresh.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_ack <= 1'b0;
      cnt <= 2'h0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack && cnt >= slow) begin
      mem_ack <= 1'b1;
      cnt <= 2'h0;
      mem_rdata <= mem[mem_addr[9:2]];
      if (mem_we)
        mem[mem_addr[9:2]] <= mem_wdata;
    end else begin
      mem_ack <= 1'b0;
      cnt <= (mem_req && !mem_ack) ? cnt + 2'h1 : 2'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// ==== tb_packet_descriptor_dma.sv ====
// Self-checking bench for the packet descriptor DMA engine.
`timescale 1ns/1ps
module tb_packet_descriptor_dma
  import pdd_pkg::*;
;
  logic        core_clk, arst_n, avs_read, avs_write, avs_waitrequest;
  logic        mem_req, mem_we, mem_ack, tx_seg_valid, tx_seg_ready;
  logic        tx_seg_first, tx_seg_last, tx_gen_crc, tx_directed;
  logic        rx_pkt_valid, rx_crc_incl, rx_jabber, rx_oversize;
  logic        rx_pkt_done, host_error, accept_error_frames;
  logic [1:0]  tx_dest_port, slow;
  logic [7:0]  avs_address;
  logic [11:0] rx_pkt_len;
  logic [15:0] tx_seg_len;
  logic [31:0] avs_writedata, avs_readdata, mem_addr, mem_wdata, mem_rdata;
  logic [31:0] tx_seg_addr, rx_buf_addr, q;
  int          errors, n_compared;
  pdd_engine    i_pdd_engine (.*);
  pdd_mem_model i_pdd_mem_model (.*);
  // Clock at 100 MHz; a hang past 40 us counts as a failure.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #40000;
    errors++;
    stop_test();
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One bus cycle; the request stands until waitrequest is seen low.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {avs_read, avs_write, avs_address, avs_writedata} <= {!w, w, a, d};
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    {avs_read, avs_write} <= 2'b00;
  endtask
  task desc(input logic [31:0] a, input logic [127:0] w);
    for (int k = 0; k < 4; k++)
      i_pdd_mem_model.mem[a[9:2] + k] = w[127 - 32 * k -: 32];
  endtask
  // Takes one segment after a stall and checks its fields.
  task seg(input logic [31:0] a, input logic [15:0] l, input logic [5:0] f);
    do @(posedge core_clk); while (tx_seg_valid !== 1'b1);
    chk(tx_seg_addr, a);
    chk({16'h0, tx_seg_len}, {16'h0, l});
    chk({26'h0, tx_seg_first, tx_seg_last, tx_gen_crc, tx_directed,
      tx_dest_port}, {26'h0, f});
    tx_seg_ready <= 1'b1;
    @(posedge core_clk);
    tx_seg_ready <= 1'b0;
  endtask
  task stop_test();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    {arst_n, avs_read, avs_write, tx_seg_ready, rx_pkt_valid} = 5'h0;
    {rx_crc_incl, rx_jabber, rx_oversize, slow} = 5'h0;
    {avs_address, avs_writedata, rx_pkt_len} = 52'h0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    // Registers: reset value, unmapped read, offset and control bit.
    bus(1'b0, REG_RX_HEAD, 32'h0);
    chk(q, RST_WORD);
    bus(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, REG_CTRL, 32'h1);
    bus(1'b1, REG_RX_OFFSET, 32'h4);
    bus(1'b0, REG_RX_OFFSET, 32'h0);
    chk(q, 32'h4);
    chk({31'h0, accept_error_frames}, 32'h1);
    $display("register test done");
    // Two-buffer directed packet truncated to 15 bytes after a 15-byte skip.
    desc(32'h40, {32'h50, 32'h1000, 32'h000F_000A, 32'hA011_000F});
    desc(32'h50, {32'h0, 32'h2000, 32'h8, 32'h4000_0000});
    bus(1'b1, REG_TX_HEAD, 32'h40);
    seg(32'h100F, 16'hA, 6'b101101);
    seg(32'h2000, 16'h5, 6'b011101);
    do bus(1'b0, REG_STATUS, 32'h0); while (q[STAT_BUSY] !== 1'b0);
    chk(i_pdd_mem_model.mem[19], 32'h8011_000F);
    chk(i_pdd_mem_model.mem[23], 32'h5000_0000);
    $display("transmit test done");
    // Error frame with CRC into an offset buffer, memory answering slowly.
    desc(32'h80, {32'h0, 32'h3000, 32'h64, 32'h2000_0000});
    bus(1'b1, REG_RX_HEAD, 32'h80);
    slow <= 2'h2;
    {rx_pkt_valid, rx_crc_incl, rx_jabber, rx_oversize} <= 4'hF;
    rx_pkt_len <= 12'h014;
    do @(posedge core_clk); while (rx_pkt_done !== 1'b1);
    rx_pkt_valid <= 1'b0;
    chk(i_pdd_mem_model.mem[34], 32'h0004_0014);
    chk(i_pdd_mem_model.mem[35], 32'hD700_0014);
    chk(rx_buf_addr, 32'h3004);
    $display("receive test done");
    // Packet handed over without ownership, then the error is cleared.
    desc(32'hC0, {32'h0, 32'h10, 32'h4, 32'hC000_0004});
    bus(1'b1, REG_TX_HEAD, 32'hC0);
    do @(posedge core_clk); while (host_error !== 1'b1);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q & 32'hF01, 32'h101);
    bus(1'b1, REG_STATUS, 32'h1);
    bus(1'b0, REG_STATUS, 32'h0);
    chk({31'h0, host_error}, 32'h0);
    $display("error test done");
    stop_test();
  end
endmodule
bind pdd_engine pdd_engine_monitor i_pdd_engine_monitor (.*);
